//--- srs_defs.vh
/*
 * Constants for the surveillance reply and status block: register
 * offsets, field positions, reset values, reply format codes and timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SRS_DEFS_VH
`define SRS_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------
`define SRS_OFF_CTRL 8'h00
`define SRS_OFF_ADDR 8'h04
`define SRS_OFF_CODE 8'h08
`define SRS_OFF_ALT 8'h0C
`define SRS_OFF_ID_LO 8'h10
`define SRS_OFF_ID_HI 8'h14
`define SRS_OFF_DLCAP 8'h18
`define SRS_OFF_CCAP 8'h1C
`define SRS_OFF_RA_LO 8'h20
`define SRS_OFF_RA_HI 8'h24
`define SRS_OFF_STAT 8'h28
`define SRS_OFF_LOCK_CLR 8'h2C

// ----------------------------------------------------------------
// Control, capability and status register fields and reset values
// ----------------------------------------------------------------
`define SRS_CTRL_GND 0
`define SRS_CTRL_RA 1
`define SRS_CTRL_SQ_EN 2
`define SRS_CTRL_LVL2 3
`define SRS_CTRL_RST 4'h9
`define SRS_DLCAP_IDENT 0
`define SRS_DLCAP_SI 1
`define SRS_DLCAP_SPEC 2
`define SRS_DLCAP_RST 3'h0
`define SRS_CCAP_RST 32'h00000000
`define SRS_STAT_ANN 16

// ----------------------------------------------------------------
// Reply register content: selector codes and bit positions
// ----------------------------------------------------------------
`define SRS_BDS_DLCAP 8'h10
`define SRS_BDS_CCAP 8'h17
`define SRS_BDS_IDENT 8'h20
`define SRS_BDS_RA 8'h30
`define SRS_MB_IDENT 23
`define SRS_MB_SI 21
`define SRS_MB_SPEC 31

// ----------------------------------------------------------------
// Interrogation kinds and reply formats
// ----------------------------------------------------------------
`define SRS_INT_ALLCALL 3'h0
`define SRS_INT_SURV_ALT 3'h1
`define SRS_INT_SURV_ID 3'h2
`define SRS_INT_COMMB_ALT 3'h3
`define SRS_INT_COMMB_ID 3'h4
`define SRS_DF_ALLCALL 5'h0B
`define SRS_DF_SURV_ALT 5'h04
`define SRS_DF_SURV_ID 5'h05
`define SRS_DF_COMMB_ALT 5'h14
`define SRS_DF_COMMB_ID 5'h15
`define SRS_CA_LVL1 3'h0
`define SRS_CA_GND 3'h4
`define SRS_CA_AIR 3'h5
`define SRS_DR_NONE 5'h00
`define SRS_DR_COMMB 5'h01
`define SRS_DR_BCAST 5'h04

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRS_CLK_HZ 50000000
`define SRS_HOLD_S 18
`define SRS_SQ_MS 1000

`endif

//--- srs_hold_timer.v
/*
 * Retriggerable hold timer: active for HOLD_CYC cycles after each start.
 * Assumes one clock, an active-low async reset and a clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
module srs_hold_timer #(
    parameter [31:0] HOLD_CYC = 32'h35A4E900
) (
    input wire pclk,          // System clock
    input wire presetn,       // Async reset, active low
    input wire ce,            // Clock enable
    input wire start,         // Start or restart pulse
    output wire active        // Hold window running
);
    reg [31:0] cnt_r;

    // A fresh start always reloads, so a second change extends the hold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h00000000;
        end else if (ce) begin
            if (start) begin
                cnt_r <= HOLD_CYC;
            end else if (cnt_r != 32'h00000000) begin
                cnt_r <= cnt_r - 32'h00000001;
            end
        end
    end

    assign active = (cnt_r != 32'h00000000);
endmodule
`default_nettype wire

//--- srs_lockout.v
/*
 * Per-interrogator all-call lockout flags, one per radar identifier.
 * Assumes set and clear come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module srs_lockout (
    input wire pclk,          // System clock
    input wire presetn,       // Async reset, active low
    input wire ce,            // Clock enable
    input wire set_en,        // Lockout command seen
    input wire [3:0] set_id,  // Radar that sent it
    input wire [15:0] clr,    // Software clear, one bit per radar
    output wire [15:0] locked // Current lockout per radar
);
    reg [15:0] lock_r;
    genvar i;

    generate
        for (i = 0; i < 16; i = i + 1) begin : g_lock
            // Set wins over a clear in the same cycle
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lock_r[i] <= 1'b0;
                end else if (ce) begin
                    if (set_en && set_id == i) begin
                        lock_r[i] <= 1'b1;
                    end else if (clr[i]) begin
                        lock_r[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign locked = lock_r;
endmodule
`default_nettype wire

//--- srs_reply.v
/*
 * Surveillance reply and status logic of a selective transponder: builds
 * replies to interrogations, sends acquisition squitters, keeps report
 * registers and times the change announcements.
 * Assumes interrogations arrive already decoded and synchronous to pclk,
 * and an APB master for the registers.
 */
//
// Behaviour
// - All-call replies only while airborne
// - Lockout command stops all-calls from that radar
// - Capability field 4..7 for level 2
// - Capability bit 33 shows identification register
// - Capability bit 35 shows lockout protocol support
// - Capability bit 25 flags specific services
// - Common capability register may read zero
// - Identification register holds aircraft identification
// - Identification change broadcast announced 18 s
// - Reply code change sets alert 18 s
// - Advisory report announced while active plus 18 s
// - All-call reply carries address and ground state
// - All-call format also sent as squitter
// - Altitude request gets short altitude reply
// - Identity request gets short code reply
// - Long altitude reply carries requested register
// - Long code reply carries requested register
`timescale 1ns/1ps
`default_nettype none
`include "srs_defs.vh"
module srs_reply #(
    parameter [31:0] HOLD_CYC = `SRS_HOLD_S * `SRS_CLK_HZ,
    parameter [31:0] SQ_CYC = (`SRS_SQ_MS * (`SRS_CLK_HZ / 1000))
) (
    input wire pclk,               // System clock, 50 MHz
    input wire presetn,            // Async reset, active low
    input wire ce,                 // Clock enable, freezes all state
    input wire [7:0] paddr,        // APB address
    input wire psel,               // APB select
    input wire penable,            // APB access phase
    input wire pwrite,             // APB write
    input wire [31:0] pwdata,      // APB write data
    output wire [31:0] prdata,     // APB read data
    output wire pready,            // APB ready
    output wire pslverr,           // APB error, unmapped address
    input wire intr_valid,         // Interrogation strobe
    input wire [2:0] intr_type,    // Interrogation kind
    input wire [23:0] intr_addr,   // Addressed aircraft, selective only
    input wire [3:0] intr_radar,   // Interrogator identifier
    input wire intr_lockout,       // Lockout command in selective call
    input wire [7:0] intr_reg,     // Requested register, long replies
    output wire reply_valid,       // Reply strobe, one cycle
    output wire [4:0] reply_df,    // Reply format
    output wire [2:0] reply_ca,    // Capability field
    output wire [2:0] reply_fs,    // Flight status, alert and ground
    output wire [4:0] reply_dr,    // Downlink request
    output wire [23:0] reply_aa,   // Aircraft address
    output wire [12:0] reply_code, // Altitude or reply code
    output wire [55:0] reply_mb,   // Register content
    output wire reply_squit,       // Reply is a squitter
    output wire announce_ident,    // Identification change running
    output wire announce_code,     // Reply code change running
    output wire announce_ra        // Advisory report present
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [3:0] ctrl_r;
    reg [23:0] aa_r;
    reg [12:0] code_r;
    reg [12:0] alt_r;
    reg [47:0] id_r;
    reg [2:0] dlcap_r;
    reg [31:0] ccap_r;
    reg [55:0] ra_r;
    reg [31:0] prdata_r;
    reg [31:0] sq_cnt_r;
    reg sq_pend_r;
    reg rv_r;
    reg [4:0] df_r;
    reg [2:0] fs_r;
    reg [4:0] dr_r;
    reg [12:0] rcode_r;
    reg [55:0] mb_r;
    reg squit_r;

    wire wr_en;
    wire rd_setup;
    wire [15:0] locked;
    wire [15:0] lock_clr;
    wire id_tmr;
    wire code_tmr;
    wire ra_tmr;
    wire code_chg;
    wire id_chg;
    wire on_gnd;
    wire [2:0] ca_val;
    wire sel_hit;
    wire lock_set;
    wire ac_ok;
    wire sq_due;

    reg [31:0] rd_mux;
    reg map_hit;
    reg [55:0] mb_sel;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Ready follows the enable so a frozen block stalls the bus
    assign pready = ce;
    assign wr_en = psel && penable && pwrite && ce && map_hit;
    assign rd_setup = psel && !penable && !pwrite && ce;
    assign pslverr = psel && penable && !map_hit;
    assign prdata = prdata_r;

    always @* begin
        map_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `SRS_OFF_CTRL: rd_mux = {28'h0000000, ctrl_r};
            `SRS_OFF_ADDR: rd_mux = {8'h00, aa_r};
            `SRS_OFF_CODE: rd_mux = {19'h00000, code_r};
            `SRS_OFF_ALT: rd_mux = {19'h00000, alt_r};
            `SRS_OFF_ID_LO: rd_mux = id_r[31:0];
            `SRS_OFF_ID_HI: rd_mux = {16'h0000, id_r[47:32]};
            `SRS_OFF_DLCAP: rd_mux = {29'h00000000, dlcap_r};
            `SRS_OFF_CCAP: rd_mux = ccap_r;
            `SRS_OFF_RA_LO: rd_mux = ra_r[31:0];
            `SRS_OFF_RA_HI: rd_mux = {8'h00, ra_r[55:32]};
            `SRS_OFF_STAT:
                rd_mux = {13'h0000, announce_ra, announce_code,
                          announce_ident, locked};
            `SRS_OFF_LOCK_CLR: rd_mux = 32'h00000000;
            default: map_hit = 1'b0;
        endcase
    end

    assign code_chg = wr_en && paddr == `SRS_OFF_CODE &&
                      pwdata[12:0] != code_r;
    assign id_chg = wr_en &&
                    ((paddr == `SRS_OFF_ID_LO && pwdata != id_r[31:0]) ||
                     (paddr == `SRS_OFF_ID_HI &&
                      pwdata[15:0] != id_r[47:32]));
    assign lock_clr = (wr_en && paddr == `SRS_OFF_LOCK_CLR) ?
                      pwdata[15:0] : 16'h0000;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SRS_CTRL_RST;
            aa_r <= 24'h000000;
            code_r <= 13'h0000;
            alt_r <= 13'h0000;
            id_r <= 48'h000000000000;
            dlcap_r <= `SRS_DLCAP_RST;
            ccap_r <= `SRS_CCAP_RST;
            ra_r <= 56'h00000000000000;
            prdata_r <= 32'h00000000;
        end else if (ce) begin
            if (rd_setup) begin
                prdata_r <= rd_mux;
            end
            if (wr_en) begin
                case (paddr)
                    `SRS_OFF_CTRL: ctrl_r <= pwdata[3:0];
                    `SRS_OFF_ADDR: aa_r <= pwdata[23:0];
                    `SRS_OFF_CODE: code_r <= pwdata[12:0];
                    `SRS_OFF_ALT: alt_r <= pwdata[12:0];
                    `SRS_OFF_ID_LO: id_r[31:0] <= pwdata;
                    `SRS_OFF_ID_HI: id_r[47:32] <= pwdata[15:0];
                    `SRS_OFF_DLCAP: dlcap_r <= pwdata[2:0];
                    `SRS_OFF_CCAP: ccap_r <= pwdata;
                    `SRS_OFF_RA_LO: ra_r[31:0] <= pwdata;
                    `SRS_OFF_RA_HI: ra_r[55:32] <= pwdata[23:0];
                    default: ctrl_r <= ctrl_r;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Change announcements
    // ----------------------------------------------------------------
    srs_hold_timer #(.HOLD_CYC(HOLD_CYC)) u_id_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .start(id_chg),
        .active(id_tmr)
    );

    srs_hold_timer #(.HOLD_CYC(HOLD_CYC)) u_code_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .start(code_chg),
        .active(code_tmr)
    );

    // Reloaded while the advisory stands, so no gap as it ends
    srs_hold_timer #(.HOLD_CYC(HOLD_CYC)) u_ra_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .start(ctrl_r[`SRS_CTRL_RA]),
        .active(ra_tmr)
    );

    assign announce_ident = id_tmr;
    assign announce_code = code_tmr;
    assign announce_ra = ctrl_r[`SRS_CTRL_RA] || ra_tmr;

    // ----------------------------------------------------------------
    // Lockout and acceptance
    // ----------------------------------------------------------------
    assign on_gnd = ctrl_r[`SRS_CTRL_GND];
    assign sel_hit = intr_valid && intr_type != `SRS_INT_ALLCALL &&
                     intr_type <= `SRS_INT_COMMB_ID &&
                     intr_addr == aa_r;
    assign lock_set = sel_hit && intr_lockout;

    srs_lockout u_lock (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set_en(lock_set),
        .set_id(intr_radar),
        .clr(lock_clr),
        .locked(locked)
    );

    assign ac_ok = intr_valid && intr_type == `SRS_INT_ALLCALL &&
                   !on_gnd && !locked[intr_radar];

    assign ca_val = !ctrl_r[`SRS_CTRL_LVL2] ? `SRS_CA_LVL1 :
                    (on_gnd ? `SRS_CA_GND : `SRS_CA_AIR);

    // ----------------------------------------------------------------
    // Requested register content
    // ----------------------------------------------------------------
    always @* begin
        mb_sel = 56'h00000000000000;
        case (intr_reg)
            `SRS_BDS_DLCAP: begin
                mb_sel[55:48] = `SRS_BDS_DLCAP;
                mb_sel[`SRS_MB_IDENT] = dlcap_r[`SRS_DLCAP_IDENT];
                mb_sel[`SRS_MB_SI] = dlcap_r[`SRS_DLCAP_SI];
                mb_sel[`SRS_MB_SPEC] = dlcap_r[`SRS_DLCAP_SPEC];
            end
            // Zero content is legal when only basic service is offered
            `SRS_BDS_CCAP: mb_sel = {24'h000000, ccap_r};
            `SRS_BDS_IDENT: mb_sel = {`SRS_BDS_IDENT, id_r};
            `SRS_BDS_RA: mb_sel = ra_r;
            default: mb_sel = 56'h00000000000000;
        endcase
    end

    // ----------------------------------------------------------------
    // Acquisition squitter
    // ----------------------------------------------------------------
    assign sq_due = sq_cnt_r == 32'h00000000;

    // A squitter that meets an interrogation reply waits for the next cycle without one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sq_cnt_r <= SQ_CYC;
            sq_pend_r <= 1'b0;
        end else if (ce) begin
            if (!ctrl_r[`SRS_CTRL_SQ_EN]) begin
                sq_cnt_r <= SQ_CYC;
                sq_pend_r <= 1'b0;
            end else begin
                sq_cnt_r <= sq_due ? SQ_CYC : sq_cnt_r - 32'h00000001;
                if (sq_due || sq_pend_r) begin
                    sq_pend_r <= ac_ok || sel_hit;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Reply builder
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rv_r <= 1'b0;
            df_r <= 5'h00;
            fs_r <= 3'h0;
            dr_r <= `SRS_DR_NONE;
            rcode_r <= 13'h0000;
            mb_r <= 56'h00000000000000;
            squit_r <= 1'b0;
        end else if (ce) begin
            rv_r <= 1'b0;
            squit_r <= 1'b0;
            fs_r <= {1'b0, code_tmr, on_gnd};
            dr_r <= id_tmr ? `SRS_DR_BCAST :
                    (announce_ra ? `SRS_DR_COMMB : `SRS_DR_NONE);
            if (ac_ok) begin
                rv_r <= 1'b1;
                df_r <= `SRS_DF_ALLCALL;
                rcode_r <= 13'h0000;
                mb_r <= 56'h00000000000000;
            end else if (sel_hit) begin
                rv_r <= 1'b1;
                case (intr_type)
                    `SRS_INT_SURV_ALT: df_r <= `SRS_DF_SURV_ALT;
                    `SRS_INT_SURV_ID: df_r <= `SRS_DF_SURV_ID;
                    `SRS_INT_COMMB_ALT: df_r <= `SRS_DF_COMMB_ALT;
                    `SRS_INT_COMMB_ID: df_r <= `SRS_DF_COMMB_ID;
                    default: rv_r <= 1'b0;
                endcase
                rcode_r <= intr_type[0] ? alt_r : code_r;
                mb_r <= (intr_type >= `SRS_INT_COMMB_ALT) ? mb_sel :
                        56'h00000000000000;
            end else if (ctrl_r[`SRS_CTRL_SQ_EN] && (sq_due || sq_pend_r)) begin
                rv_r <= 1'b1;
                squit_r <= 1'b1;
                df_r <= `SRS_DF_ALLCALL;
                rcode_r <= 13'h0000;
                mb_r <= 56'h00000000000000;
            end
        end
    end

    assign reply_valid = rv_r;
    assign reply_df = df_r;
    assign reply_ca = ca_val;
    assign reply_fs = fs_r;
    assign reply_dr = dr_r;
    assign reply_aa = aa_r;
    assign reply_code = rcode_r;
    assign reply_mb = mb_r;
    assign reply_squit = squit_r;
endmodule
`default_nettype wire

//--- srs_end.v
/*
 * Intentionally empty compilation unit.
 * Assumes nothing.
 */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- srs_reply_properties.sv
/* Port checker for srs_reply, attached by the bind at the foot.
   Assumes ce stays high while announcements run. */
`timescale 1ns/1ps
`default_nettype none
module srs_reply_properties #(
    parameter [31:0] HOLD_CYC = 32'h14
) (
    input wire logic pclk, // clk
    input wire logic presetn, // reset
    input wire logic ce, // enable
    input wire logic intr_valid, // strobe
    input wire logic [2:0] intr_type, // kind
    input wire logic reply_valid, // reply
    input wire logic [4:0] reply_df, // format
    input wire logic [2:0] reply_ca, // capability
    input wire logic [2:0] reply_fs, // status
    input wire logic [12:0] reply_code, // code
    input wire logic [55:0] reply_mb, // content
    input wire logic reply_squit, // squitter
    input wire logic announce_code, // code hold
    input wire logic announce_ra // advisory
);
// ------------------------------
// Run-length counters
// ------------------------------
localparam logic [4:0] DF [0:4] = '{5'h0B, 5'h04, 5'h05, 5'h14, 5'h15};
logic warm;
logic [31:0] code_run, ra_run;
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        warm <= 1'b0;
        code_run <= 32'h0;
        ra_run <= 32'h0;
    end else begin
        warm <= 1'b1;
        code_run <= announce_code ? code_run + 32'h1 : 32'h0;
        ra_run <= announce_ra ? ra_run + 32'h1 : 32'h0;
    end
end
// ------------------------------
// Properties
// ------------------------------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_answer;
    reply_valid && !reply_squit;
endsequence
sequence s_gnd_allcall;
    intr_valid && ce && intr_type == 3'h0 && reply_fs[0];
endsequence
a_ground_silent: assert property (
    s_gnd_allcall |=> !reply_valid || reply_squit)
    else $error("all-call answered on ground");
a_reply_cause: assert property (s_answer |-> $past(intr_valid))
    else $error("reply without interrogation");
a_format_map: assert property (
    s_answer |-> reply_df == DF[$past(intr_type)])
    else $error("wrong reply format");
a_squit_shape: assert property (
    reply_squit |-> reply_valid && reply_df == 5'h0B)
    else $error("squitter format wrong");
a_allcall_body: assert property (
    reply_valid && reply_df == 5'h0B |-> reply_code == 13'h0
    && reply_mb == 56'h0)
    else $error("all-call reply body not empty");
a_ca_level2: assert property (reply_ca != 3'h0 |-> reply_ca[2])
    else $error("capability outside 4 to 7");
a_ca_ground: assert property (
    warm && ce && $stable(reply_ca) && reply_ca[2]
    |-> reply_ca[0] != reply_fs[0])
    else $error("capability disagrees with ground state");
a_code_hold: assert property (
    $fell(announce_code) |-> code_run >= HOLD_CYC)
    else $error("code announcement too short");
a_ra_hold: assert property ($fell(announce_ra) |-> ra_run > HOLD_CYC)
    else $error("advisory announcement too short");
endmodule
bind srs_reply srs_reply_properties #(.HOLD_CYC(HOLD_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .intr_valid(intr_valid),
    .intr_type(intr_type), .reply_valid(reply_valid), .reply_df(reply_df),
    .reply_ca(reply_ca), .reply_fs(reply_fs), .reply_code(reply_code),
    .reply_mb(reply_mb), .reply_squit(reply_squit),
    .announce_code(announce_code), .announce_ra(announce_ra));
`default_nettype wire

//--- srs_radar.sv
/* Ground interrogator model: sends decoded interrogations.
   Assumes the bench calls send and samples the reply itself. */
`timescale 1ns/1ps
`default_nettype none
module srs_radar (
    input wire logic pclk, // clk
    output logic intr_valid, // strobe
    output logic [2:0] intr_type, // kind
    output logic [23:0] intr_addr, // target
    output logic [3:0] intr_radar, // own id
    output logic intr_lockout, // lockout
    output logic [7:0] intr_reg // register
);
// ------------------------------
// Interrogation driver
// ------------------------------
initial begin
    intr_valid = 1'b0;
    intr_type = 3'h7;
    intr_addr = 24'h0;
    intr_radar = 4'h0;
    intr_lockout = 1'b0;
    intr_reg = 8'h00;
end
// Fields other than the radar id are scrambled once released so stale values never pass
task send(input logic [2:0] t, input logic [23:0] a, input logic [3:0] r,
          input logic l, input logic [7:0] g);
    @(posedge pclk);
    intr_valid <= 1'b1;
    intr_type <= t;
    intr_addr <= a;
    intr_radar <= r;
    intr_lockout <= l;
    intr_reg <= g;
    @(posedge pclk);
    intr_valid <= 1'b0;
    intr_type <= ~t;
    intr_addr <= ~a;
    intr_lockout <= ~l;
    intr_reg <= ~g;
endtask
endmodule
`default_nettype wire

//--- srs_reply_bench.sv
/* Bench for srs_reply: APB tasks, radar partner, reply checks.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module srs_reply_bench;
// ------------------------------
// Set-up
// ------------------------------
localparam int HOLD = 20;
localparam logic [23:0] AA = 24'hABC123;
logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0;
logic penable = 1'b0, pwrite = 1'b0, lk = 1'b0, rerr;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, rdat;
logic [23:0] dst = AA;
int fails = 0, check_count = 0, i;
wire pready, pslverr, intr_valid, intr_lockout, reply_valid, reply_squit;
wire announce_ident, announce_code, announce_ra;
wire [31:0] prdata;
wire [2:0] intr_type, reply_ca, reply_fs;
wire [23:0] intr_addr, reply_aa;
wire [3:0] intr_radar;
wire [7:0] intr_reg;
wire [4:0] reply_df, reply_dr;
wire [12:0] reply_code;
wire [55:0] reply_mb;
wire [2:0] ann = {announce_ident, announce_code, announce_ra};
wire [10:0] cap = {reply_mb[55:48], reply_mb[31], reply_mb[23], reply_mb[21]};
srs_reply #(.HOLD_CYC(HOLD), .SQ_CYC(32'h1E)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .intr_valid(intr_valid),
    .intr_type(intr_type), .intr_addr(intr_addr), .intr_radar(intr_radar),
    .intr_lockout(intr_lockout), .intr_reg(intr_reg),
    .reply_valid(reply_valid), .reply_df(reply_df), .reply_ca(reply_ca),
    .reply_fs(reply_fs), .reply_dr(reply_dr), .reply_aa(reply_aa),
    .reply_code(reply_code), .reply_mb(reply_mb), .reply_squit(reply_squit),
    .announce_ident(announce_ident), .announce_code(announce_code),
    .announce_ra(announce_ra));
srs_radar radar (.pclk(pclk), .intr_valid(intr_valid),
    .intr_type(intr_type), .intr_addr(intr_addr), .intr_radar(intr_radar),
    .intr_lockout(intr_lockout), .intr_reg(intr_reg));
always #10 pclk = ~pclk;
// ------------------------------
// Tasks
// ------------------------------
task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
        fails++;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
endtask
task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
endtask
task rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    apb(a, 1'b0, 32'h0);
    chk("prdata", e, rdat);
    chk("pslverr", er, rerr);
endtask
task ask(input logic [2:0] t, input logic [7:0] g, input logic [3:0] r,
         input logic e);
    radar.send(t, dst, r, lk, g);
    #1;
    chk("reply_valid", e, reply_valid);
endtask
// Counts high cycles of one announcement after the triggering write
task span(input int k);
    int n;
    n = 0;
    repeat (HOLD + 10) begin
        @(posedge pclk);
        #1;
        if (ann[k] === 1'b1)
            n++;
    end
    chk("hold", HOLD - 1, n);
endtask
task close_out;
    if (fails == 0 && check_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
// ------------------------------
// Scenarios
// ------------------------------
initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h00000009, 1'b0);
    rd(8'h1C, 32'h00000000, 1'b0);
    rd(8'h30, 32'h00000000, 1'b1);
    wr(8'h04, {8'h00, AA});
    wr(8'h0C, 32'h00000123);
    wr(8'h08, 32'h00000A5A);
    wr(8'h10, 32'h11223344);
    wr(8'h14, 32'h00005566);
    wr(8'h20, 32'h89ABCDEF);
    wr(8'h24, 32'h00456789);
    wr(8'h18, 32'h00000005);
    ask(3'h0, 8'h00, 4'h3, 1'b0);
    wr(8'h00, 32'h00000000);
    ask(3'h0, 8'h00, 4'h3, 1'b1);
    chk("reply_ca", 3'h0, reply_ca);
    wr(8'h00, 32'h00000008);
    ask(3'h0, 8'h00, 4'h3, 1'b1);
    chk("df_aa_ca", {5'h0B, AA, 3'h5}, {reply_df, reply_aa, reply_ca});
    lk = 1'b1;
    ask(3'h1, 8'h00, 4'h3, 1'b1);
    lk = 1'b0;
    chk("alt", {5'h04, 13'h0123}, {reply_df, reply_code});
    ask(3'h0, 8'h00, 4'h3, 1'b0);
    ask(3'h0, 8'h00, 4'h4, 1'b1);
    wr(8'h2C, 32'h00000008);
    ask(3'h0, 8'h00, 4'h3, 1'b1);
    ask(3'h2, 8'h00, 4'h3, 1'b1);
    chk("ident", {5'h05, 13'h0A5A}, {reply_df, reply_code});
    ask(3'h3, 8'h20, 4'h3, 1'b1);
    chk("mb_id", {8'h20, 48'h556611223344}, reply_mb);
    ask(3'h4, 8'h10, 4'h3, 1'b1);
    chk("mb_cap", {8'h10, 3'b110}, cap);
    if (cap[2] === 1'b1)
        ask(3'h4, 8'h17, 4'h3, 1'b1);
    chk("mb_ccap", 56'h0, reply_mb);
    ask(3'h3, 8'h30, 4'h3, 1'b1);
    chk("mb_ra", {24'h456789, 32'h89ABCDEF}, reply_mb);
    dst = AA + 24'h1;
    ask(3'h1, 8'h00, 4'h3, 1'b0);
    dst = AA;
    wr(8'h08, 32'h00000A5B);
    ask(3'h2, 8'h00, 4'h3, 1'b1);
    chk("alert", {1'b1, 13'h0A5B}, {reply_fs[1], reply_code});
    wr(8'h08, 32'h00000A5C);
    span(1);
    ask(3'h2, 8'h00, 4'h3, 1'b1);
    chk("alert_end", 1'b0, reply_fs[1]);
    wr(8'h10, 32'h11223345);
    ask(3'h1, 8'h00, 4'h3, 1'b1);
    chk("dr_ident", 5'h04, reply_dr);
    wr(8'h14, 32'h00005567);
    span(2);
    wr(8'h00, 32'h0000000A);
    ask(3'h1, 8'h00, 4'h3, 1'b1);
    chk("dr_ra", 5'h01, reply_dr);
    wr(8'h00, 32'h00000008);
    span(0);
    ask(3'h1, 8'h00, 4'h3, 1'b1);
    chk("dr_none", 5'h00, reply_dr);
    wr(8'h00, 32'h0000000C);
    for (i = 0; i < 40 && reply_squit !== 1'b1; i++) begin
        @(posedge pclk);
        #1;
    end
    chk("squit", {1'b1, 5'h0B}, {reply_squit, reply_df});
    close_out();
end
initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    close_out();
end
endmodule
`default_nettype wire
